// ==== logic/sdlbc_top.sv ====
// Receive link bring-up register bank with serial control port and lane datapath
// Behaviour
// - CDR half-rate bit 5 and oversample bit 1 of cdr_clocking_config drive the CDR.
// - Divider select in serdes_pll_divider bits [1:0]; host keeps bit 2 at one.
// - Writing 0x01 to serdes_pll_enable enables the SERDES PLL after CDR release.
// - Bit 0 of serdes_pll_lock_status reads one once the enabled PLL has locked while the CDR is released.
// - Equalizer mode in rx_equalizer_config bits [7:6]; bits [5:0] stay 0x22.
// - LMFC delay at lmfc_delay and window at lmfc_variable_window, written before arming.
// - 0x3A written 0x01, 0x81, 0xC1: one-shot, enable, then arm.
// - Armed machine aligns on SYSREF and sets bit 3 of 0x3B.
// - Crossbar values at lane_crossbar_low and lane_crossbar_high remap physical to logical lanes.
// - Bit x of lane_polarity_invert inverts logical lane x; zero leaves it unchanged.
// - link_control bit 6 selects checksum mode, bit 0 enables the link.
// - Lane count is given minus one; three means four lanes.
`timescale 1ns/100ps
`default_nettype none
module sdlbc_top
    import sdlbc_pkg::*;
(
    input  wire logic                       CLK_SYS,
    input  wire logic                       SYS_RST,
    input  wire logic                       SPI_CS_N,
    input  wire logic                       SPI_SCLK,
    input  wire logic                       SPI_SDI,
    output logic                            SPI_SDO,
    output logic                            SPI_SDO_OE,
    input  wire logic                       PLL_LOCK_IN,
    input  wire logic                       SYSREF_IN,
    input  wire logic [4:0]                 LANE_COUNT_M1,
    input  wire logic [LANE_N*LANE_W-1:0]   LANE_DATA_IN,
    output logic [LANE_N*LANE_W-1:0]        LANE_DATA_OUT,
    output logic                            CDR_RELEASE,
    output logic                            CDR_HALFRATE,
    output logic                            CDR_OVERSAMPLE_SEL,
    output logic [1:0]                      SERDES_PLL_DIVIDER_SEL,
    output logic                            SERDES_PLL_ENABLE,
    output logic [1:0]                      EQUALIZER_MODE_SEL,
    output logic                            CHECKSUM_METHOD_SEL,
    output logic                            LINK_ENABLE,
    output logic                            LINK_SYNC_REQUEST_OUT_N,
    output logic                            LMFC_PULSE
);
    // ====================================================================
    // Functions
    function automatic logic [7:0] reg_read(input sdlbc_state_type s, input logic [14:0] a);
        logic [7:0] v;
        v = RST_ZERO;
        unique case (a)
            A_SYNC_CTL: v = s.rg.sync_ctl;
            A_SYNC_STA: v = 8'(s.sync_done) << B_SYNC_DONE;
            A_CDR_RST:  v = s.rg.cdr_rst;
            A_CDR_CLK:  v = s.rg.cdr_clk;
            A_EQ_CFG:   v = s.rg.eq_cfg;
            A_PLL_EN:   v = s.rg.pll_en;
            A_PLL_LOCK: v = 8'(s.pll_lock);
            A_PLL_DIV:  v = s.rg.pll_div;
            A_AUTOTUNE: v = s.rg.autotune;
            A_LINK_CTL: v = s.rg.link_ctl;
            A_SUBCLASS: v = s.rg.subclass;
            A_LMFC_DEL: v = s.rg.lmfc_del;
            A_LMFC_WIN: v = s.rg.lmfc_win;
            A_XBAR_LO:  v = s.rg.xbar_lo;
            A_XBAR_HI:  v = s.rg.xbar_hi;
            A_PORT_CFG: v = s.rg.port_cfg;
            A_POLARITY: v = s.rg.polarity;
            default:    v = RST_ZERO;
        endcase
        return v;
    endfunction : reg_read

    function automatic logic [1:0] xbar_src(input sdlbc_regs_type r, input int i);
        logic [7:0] b;
        b = (i < 2) ? r.xbar_lo : r.xbar_hi;
        return b[(i % 2)*XBAR_FW +: 2];
    endfunction : xbar_src

    // ====================================================================
    // State
    sdlbc_state_type s_r;
    sdlbc_state_type s_nxt;
    logic            rise;
    logic            fall;
    logic            wr_hit;
    logic [14:0]     wr_addr;
    logic [7:0]      wr_data;
    logic            align;
    logic [LANE_W-1:0] lw;

    always_comb begin
        s_nxt   = s_r;
        lw      = '0;
        rise    = SPI_SCLK & ~s_r.sclk_q;
        fall    = ~SPI_SCLK & s_r.sclk_q;
        wr_hit  = 1'b0;
        wr_addr = s_r.instr[14:0];
        wr_data = {s_r.wdat[6:0], SPI_SDI};
        s_nxt.sclk_q   = SPI_SCLK;
        s_nxt.sysref_q = SYSREF_IN;
        // Serial port: 16-bit instruction then one data byte, MSB first
        if (SPI_CS_N) begin
            s_nxt.phase  = SPI_IDLE;
            s_nxt.cnt    = '0;
            s_nxt.sdo_oe = 1'b0;
            s_nxt.sdo    = 1'b0;
        end else begin
            if (s_r.phase == SPI_IDLE) begin
                s_nxt.phase = SPI_INSTR;
            end
            if (rise && s_r.phase != SPI_DONE) begin
                s_nxt.cnt = s_r.cnt + 5'h01;
                if (s_r.phase != SPI_DATA) begin
                    s_nxt.instr = {s_r.instr[14:0], SPI_SDI};
                    if (s_r.cnt == SPI_INSTR_LAST) begin
                        s_nxt.phase = SPI_DATA;
                        s_nxt.rdat  = reg_read(s_r, {s_r.instr[13:0], SPI_SDI});
                    end
                end else begin
                    s_nxt.wdat = wr_data;
                    if (s_r.cnt == SPI_DATA_LAST) begin
                        s_nxt.phase = SPI_DONE;
                        wr_hit      = ~s_r.instr[15];
                    end
                end
            end
            if (fall && s_r.phase == SPI_DATA && s_r.instr[15]) begin
                s_nxt.sdo    = s_r.rdat[7];
                s_nxt.sdo_oe = 1'b1;
                s_nxt.rdat   = {s_r.rdat[6:0], 1'b0};
            end
        end
        // Register writes; read-only and unmapped offsets are ignored
        if (wr_hit) begin
            unique case (wr_addr)
                A_SYNC_CTL: begin
                    s_nxt.rg.sync_ctl = wr_data;
                    s_nxt.sync_done   = 1'b0;
                end
                A_CDR_RST:  s_nxt.rg.cdr_rst  = wr_data;
                A_CDR_CLK:  s_nxt.rg.cdr_clk  = wr_data;
                A_EQ_CFG:   s_nxt.rg.eq_cfg   = wr_data;
                A_PLL_EN:   s_nxt.rg.pll_en   = wr_data;
                A_PLL_DIV:  s_nxt.rg.pll_div  = wr_data;
                A_AUTOTUNE: s_nxt.rg.autotune = wr_data;
                A_LINK_CTL: s_nxt.rg.link_ctl = wr_data;
                A_SUBCLASS: s_nxt.rg.subclass = wr_data;
                A_LMFC_DEL: s_nxt.rg.lmfc_del = wr_data;
                A_LMFC_WIN: s_nxt.rg.lmfc_win = wr_data;
                A_XBAR_LO:  s_nxt.rg.xbar_lo  = wr_data;
                A_XBAR_HI:  s_nxt.rg.xbar_hi  = wr_data;
                A_PORT_CFG: s_nxt.rg.port_cfg = wr_data;
                A_POLARITY: s_nxt.rg.polarity = wr_data;
                default:    s_nxt.rg = s_r.rg;
            endcase
        end
        // Lock is seen only while the PLL is enabled and the CDR released
        s_nxt.pll_lock = s_r.rg.pll_en[0] & s_r.rg.cdr_rst[0] & PLL_LOCK_IN;
        // One-shot sync: armed machine aligns on SYSREF rising edge
        align = s_r.rg.sync_ctl[B_SYNC_EN] & s_r.rg.sync_ctl[B_SYNC_ARM]
              & SYSREF_IN & ~s_r.sysref_q;
        if (align) begin
            s_nxt.sync_done = 1'b1;
            s_nxt.lmfc_cnt  = s_r.rg.lmfc_del;
            if (s_r.rg.sync_ctl[B_SYNC_ONE] && !(wr_hit && wr_addr == A_SYNC_CTL)) begin
                s_nxt.rg.sync_ctl[B_SYNC_ARM] = 1'b0;
            end
        end else if (s_r.lmfc_cnt >= LMFC_PERIOD - 8'h01) begin
            s_nxt.lmfc_cnt = '0;
        end else begin
            s_nxt.lmfc_cnt = s_r.lmfc_cnt + 8'h01;
        end
        s_nxt.lmfc_pulse = (s_r.lmfc_cnt == LMFC_PERIOD - 8'h01);
        // Link: remap, invert, drop lanes beyond the minus-one count
        s_nxt.sync_req_n = s_r.rg.link_ctl[B_LINK_EN];
        for (int i = 0; i < LANE_N; i++) begin
            lw = LANE_DATA_IN[32'(xbar_src(s_r.rg, i))*LANE_W +: LANE_W];
            if (s_r.rg.link_ctl[B_LINK_EN] && 5'(i) <= LANE_COUNT_M1) begin
                s_nxt.lanes[i*LANE_W +: LANE_W] = lw ^ {LANE_W{s_r.rg.polarity[i]}};
            end else begin
                s_nxt.lanes[i*LANE_W +: LANE_W] = '0;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            s_r            <= '0;
            s_r.phase      <= SPI_IDLE;
            s_r.rg.cdr_clk <= RST_CDRCLK;
            s_r.rg.pll_div <= RST_SERDES_PLL_DIVIDER_SEL;
            s_r.rg.eq_cfg  <= RST_EQ;
            s_r.sync_req_n <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ====================================================================
    // Outputs
    assign SPI_SDO                 = s_r.sdo;
    assign SPI_SDO_OE              = s_r.sdo_oe;
    assign LANE_DATA_OUT           = s_r.lanes;
    assign CDR_RELEASE             = s_r.rg.cdr_rst[0];
    assign CDR_HALFRATE            = s_r.rg.cdr_clk[B_HALFRATE];
    assign CDR_OVERSAMPLE_SEL      = s_r.rg.cdr_clk[B_OVERSAMPLE];
    assign SERDES_PLL_DIVIDER_SEL  = s_r.rg.pll_div[B_DIV_LO +: 2];
    assign SERDES_PLL_ENABLE       = s_r.rg.pll_en[0];
    assign EQUALIZER_MODE_SEL      = s_r.rg.eq_cfg[B_EQ_LO +: 2];
    assign CHECKSUM_METHOD_SEL     = s_r.rg.link_ctl[B_CHECKSUM];
    assign LINK_ENABLE             = s_r.rg.link_ctl[B_LINK_EN];
    assign LINK_SYNC_REQUEST_OUT_N = s_r.sync_req_n;
    assign LMFC_PULSE              = s_r.lmfc_pulse;

    // ====================================================================
    // Assertions
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    sequence armed_edge;
        s_r.rg.sync_ctl[B_SYNC_EN] && s_r.rg.sync_ctl[B_SYNC_ARM] && SYSREF_IN && !s_r.sysref_q;
    endsequence
    sequence no_ctl_write;
        !(wr_hit && wr_addr == A_SYNC_CTL);
    endsequence

    a_sync_done_set: assert property (armed_edge |=> s_r.sync_done)
        else $error("sync status not set after armed SYSREF edge");
    a_arm_self_clear: assert property (armed_edge ##0 no_ctl_write
        ##0 s_r.rg.sync_ctl[B_SYNC_ONE] |=> !s_r.rg.sync_ctl[B_SYNC_ARM])
        else $error("one-shot arm bit did not clear");
    a_lmfc_realign: assert property (armed_edge |=> s_r.lmfc_cnt == $past(s_r.rg.lmfc_del))
        else $error("LMFC phase not loaded from delay");
    a_pll_lock: assert property (!SERDES_PLL_ENABLE |=> !s_r.pll_lock)
        else $error("lock reported while PLL disabled");
    a_link_gate: assert property (!LINK_ENABLE ##1 !LINK_ENABLE |-> LANE_DATA_OUT == '0)
        else $error("lane data passed while link disabled");
    a_sync_request: assert property ($rose(LINK_ENABLE) |=> LINK_SYNC_REQUEST_OUT_N)
        else $error("sync request not released after link enable");
    a_lane_polarity: assert property (LINK_ENABLE && s_r.rg.xbar_lo[1:0] == 2'h3
        |=> LANE_DATA_OUT[LANE_W-1:0]
            == ($past(LANE_DATA_IN[LANE_N*LANE_W-1:(LANE_N-1)*LANE_W])
            ^ {LANE_W{$past(s_r.rg.polarity[0])}}))
        else $error("logical lane 0 polarity wrong");
    a_reg_write: assert property (wr_hit && wr_addr == A_CDR_CLK
        |=> ##1 CDR_HALFRATE == $past(wr_data[B_HALFRATE], 2))
        else $error("CDR half-rate not taken from write");
    a_eq_default: assert property ($fell(SYS_RST) |-> s_r.rg.eq_cfg == RST_EQ)
        else $error("equalizer default wrong after reset");
    a_rst_defaults: assert property ($fell(SYS_RST)
        |-> s_r.rg.cdr_clk == RST_CDRCLK && s_r.rg.pll_div == RST_SERDES_PLL_DIVIDER_SEL)
        else $error("PHY defaults wrong after reset");

    // ====================================================================
    // Assertions: register writes and readback
    a_cdr_release: assert property (wr_hit && wr_addr == A_CDR_RST
        |=> CDR_RELEASE == $past(wr_data[0]))
        else $error("CDR release not taken from write");
    a_cdr_oversample: assert property (wr_hit && wr_addr == A_CDR_CLK
        |=> CDR_OVERSAMPLE_SEL == $past(wr_data[B_OVERSAMPLE]))
        else $error("CDR oversample not taken from write");
    a_pll_divider: assert property (wr_hit && wr_addr == A_PLL_DIV
        |=> SERDES_PLL_DIVIDER_SEL == $past(wr_data[B_DIV_LO +: 2]))
        else $error("PLL divider not taken from write");
    a_pll_enable: assert property (wr_hit && wr_addr == A_PLL_EN
        |=> SERDES_PLL_ENABLE == $past(wr_data[0]))
        else $error("PLL enable not taken from write");
    a_lock_seen: assert property (SERDES_PLL_ENABLE && CDR_RELEASE
        && PLL_LOCK_IN |=> s_r.pll_lock)
        else $error("lock not reported while PLL enabled");
    a_lock_drop: assert property (!PLL_LOCK_IN
        |=> !s_r.pll_lock)
        else $error("lock reported without lock input");
    a_eq_mode: assert property (wr_hit && wr_addr == A_EQ_CFG
        |=> EQUALIZER_MODE_SEL == $past(wr_data[B_EQ_LO +: 2]))
        else $error("equalizer mode not taken from write");
    a_lmfc_delay: assert property (wr_hit && wr_addr == A_LMFC_DEL
        |=> s_r.rg.lmfc_del == $past(wr_data))
        else $error("LMFC delay not stored");
    a_lmfc_window: assert property (wr_hit && wr_addr == A_LMFC_WIN
        |=> s_r.rg.lmfc_win == $past(wr_data))
        else $error("LMFC window not stored");
    a_xbar_low: assert property (wr_hit && wr_addr == A_XBAR_LO
        |=> s_r.rg.xbar_lo == $past(wr_data))
        else $error("crossbar low not stored");
    a_xbar_high: assert property (wr_hit && wr_addr == A_XBAR_HI
        |=> s_r.rg.xbar_hi == $past(wr_data))
        else $error("crossbar high not stored");
    a_polarity_reg: assert property (wr_hit && wr_addr == A_POLARITY
        |=> s_r.rg.polarity == $past(wr_data))
        else $error("polarity mask not stored");
    a_link_ctl: assert property (wr_hit && wr_addr == A_LINK_CTL
        |=> {CHECKSUM_METHOD_SEL, LINK_ENABLE} == $past({wr_data[B_CHECKSUM], wr_data[B_LINK_EN]}))
        else $error("link control not taken from write");
    a_status_ro: assert property (wr_hit && !align
        && (wr_addr == A_SYNC_STA || wr_addr == A_PLL_LOCK) |=> s_r.rg == $past(s_r.rg))
        else $error("status write changed a register");
    a_sdo_release: assert property (SPI_CS_N
        |=> !SPI_SDO_OE && !SPI_SDO)
        else $error("serial output driven while deselected");
    a_read_oe: assert property (SPI_SDO_OE
        |-> s_r.instr[15])
        else $error("serial output driven in a write frame");

    // ====================================================================
    // Assertions: sync machine and LMFC phase
    a_sync_ctl_wr: assert property (wr_hit && wr_addr == A_SYNC_CTL
        |=> s_r.rg.sync_ctl == $past(wr_data))
        else $error("sync control write lost");
    a_sync_clear: assert property (wr_hit && wr_addr == A_SYNC_CTL && !align
        |=> !s_r.sync_done)
        else $error("sync status not cleared by control write");
    a_sync_hold: assert property (!align && !(wr_hit && wr_addr == A_SYNC_CTL)
        |=> s_r.sync_done == $past(s_r.sync_done))
        else $error("sync status changed without cause");
    a_lmfc_wrap: assert property (s_r.lmfc_cnt == LMFC_PERIOD - 8'h01
        |=> LMFC_PULSE)
        else $error("LMFC pulse missing at phase end");
    a_lmfc_quiet: assert property (s_r.lmfc_cnt != LMFC_PERIOD - 8'h01
        |=> !LMFC_PULSE)
        else $error("LMFC pulse outside phase end");
    a_lmfc_step: assert property (!align && s_r.lmfc_cnt < LMFC_PERIOD - 8'h01
        |=> s_r.lmfc_cnt == $past(s_r.lmfc_cnt) + 8'h01)
        else $error("LMFC phase did not advance");
    a_lmfc_zero: assert property (!align && s_r.lmfc_cnt >= LMFC_PERIOD - 8'h01
        |=> s_r.lmfc_cnt == 8'h00)
        else $error("LMFC phase did not wrap");

    // ====================================================================
    // Assertions: link datapath
    a_sync_req_low: assert property (!LINK_ENABLE
        |=> !LINK_SYNC_REQUEST_OUT_N)
        else $error("sync request released while link disabled");
    a_lane_count: assert property (LINK_ENABLE && LANE_COUNT_M1 < 5'h03
        |=> LANE_DATA_OUT[LANE_N*LANE_W-1:(LANE_N-1)*LANE_W] == '0)
        else $error("lane beyond count not zeroed");
    a_lane_remap: assert property (LINK_ENABLE && s_r.rg.xbar_hi[4:3] == 2'h0
        && LANE_COUNT_M1 >= 5'h03 && !s_r.rg.polarity[3]
        |=> LANE_DATA_OUT[LANE_N*LANE_W-1:(LANE_N-1)*LANE_W] == $past(LANE_DATA_IN[LANE_W-1:0]))
        else $error("logical lane 3 not taken from its source");
endmodule : sdlbc_top
`default_nettype wire

// ==== logic/sdlbc_pkg.sv ====
// Package: register map, field positions, reset values and state types
package sdlbc_pkg;
    // ====================================================================
    // Register offsets
    localparam logic [14:0] A_SYNC_CTL  = 15'h003A;
    localparam logic [14:0] A_SYNC_STA  = 15'h003B;
    localparam logic [14:0] A_CDR_RST   = 15'h0206;
    localparam logic [14:0] A_CDR_CLK   = 15'h0230;
    localparam logic [14:0] A_EQ_CFG    = 15'h0268;
    localparam logic [14:0] A_PLL_EN    = 15'h0280;
    localparam logic [14:0] A_PLL_LOCK  = 15'h0281;
    localparam logic [14:0] A_PLL_DIV   = 15'h0289;
    localparam logic [14:0] A_AUTOTUNE  = 15'h02A7;
    localparam logic [14:0] A_LINK_CTL  = 15'h0300;
    localparam logic [14:0] A_SUBCLASS  = 15'h0301;
    localparam logic [14:0] A_LMFC_DEL  = 15'h0304;
    localparam logic [14:0] A_LMFC_WIN  = 15'h0306;
    localparam logic [14:0] A_XBAR_LO   = 15'h0308;
    localparam logic [14:0] A_XBAR_HI   = 15'h0309;
    localparam logic [14:0] A_PORT_CFG  = 15'h0314;
    localparam logic [14:0] A_POLARITY  = 15'h0334;
    // ====================================================================
    // Field positions
    localparam int B_HALFRATE   = 5;
    localparam int B_OVERSAMPLE = 1;
    localparam int B_DIV_LO     = 0;
    localparam int B_EQ_LO      = 6;
    localparam int B_SYNC_ONE   = 0;
    localparam int B_SYNC_ARM   = 6;
    localparam int B_SYNC_EN    = 7;
    localparam int B_SYNC_DONE  = 3;
    localparam int B_CHECKSUM   = 6;
    localparam int B_LINK_EN    = 0;
    localparam int XBAR_FW      = 3;
    // ====================================================================
    // Reset values, serial frame and datapath sizes
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_CDRCLK = 8'h09;
    localparam logic [7:0] RST_SERDES_PLL_DIVIDER_SEL = 8'h04;
    localparam logic [7:0] RST_EQ     = 8'h22;
    localparam logic [4:0] SPI_INSTR_LAST = 5'h0F;
    localparam logic [4:0] SPI_DATA_LAST  = 5'h17;
    localparam int LANE_N  = 4;
    localparam int LANE_W  = 10;
    localparam logic [7:0] LMFC_PERIOD = 8'h20;
    // ====================================================================
    // Types
    typedef enum logic [1:0] {SPI_IDLE, SPI_INSTR, SPI_DATA, SPI_DONE} sdlbc_spi_type;
    typedef struct packed {
        logic [7:0] sync_ctl, cdr_rst, cdr_clk, eq_cfg, pll_en, pll_div, autotune;
        logic [7:0] link_ctl, subclass, lmfc_del, lmfc_win, xbar_lo, xbar_hi;
        logic [7:0] port_cfg, polarity;
    } sdlbc_regs_type;
    typedef struct packed {
        sdlbc_regs_type                 rg;
        logic                           sync_done;
        logic                           pll_lock;
        sdlbc_spi_type                  phase;
        logic                           sclk_q;
        logic [4:0]                     cnt;
        logic [15:0]                    instr;
        logic [7:0]                     wdat;
        logic [7:0]                     rdat;
        logic                           sdo;
        logic                           sdo_oe;
        logic                           sysref_q;
        logic [7:0]                     lmfc_cnt;
        logic                           lmfc_pulse;
        logic                           sync_req_n;
        logic [LANE_N*LANE_W-1:0]       lanes;
    } sdlbc_state_type;
endpackage : sdlbc_pkg

// ==== tb/sdlbc_tx_model.sv ====
// Transmitter model: drives four lanes with fixed per-lane filler, then per-lane patterns that change every cycle once sync is released
`timescale 1ns/100ps
`default_nettype none
module sdlbc_tx_model
    import sdlbc_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    input  wire logic                 sync_req_n,
    output logic [LANE_N*LANE_W-1:0]  lane_data
);
    logic [7:0] cnt_r;
    // ====================================================================
    // Comma-like filler while sync is requested, counting data otherwise
    always @(negedge clk_sys) begin
        cnt_r <= (sys_rst || !sync_req_n) ? 8'h00 : cnt_r + 8'h01;
        for (int p = 0; p < LANE_N; p++) begin
            lane_data[p*LANE_W+:LANE_W] <= sync_req_n ? {p[1:0], cnt_r} : 10'h17C ^ p[9:0];
        end
    end
endmodule : sdlbc_tx_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench: serial register access, PHY bring-up, sync machine and lane mapping
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); end end
module tb_top
    import sdlbc_pkg::*;
;
    logic        clk_sys = 1'b0;
    logic        sys_rst, cs_n, sclk, sdi, sdo, sdo_oe, lock_in, sysref;
    logic        cdr_rel, cdr_hr, cdr_os, pll_en, cks_sel, link_en, sync_n, lmfc_p;
    logic [1:0]  pll_div, eq_mode;
    logic [4:0]  lane_m1;
    logic [39:0] lane_in, lane_out, prev_in;
    int          n_fail = 0;
    int          n_checks = 0;
    sdlbc_top u_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .SPI_CS_N(cs_n),
        .SPI_SCLK(sclk), .SPI_SDI(sdi), .SPI_SDO(sdo), .SPI_SDO_OE(sdo_oe),
        .PLL_LOCK_IN(lock_in), .SYSREF_IN(sysref), .LANE_COUNT_M1(lane_m1),
        .LANE_DATA_IN(lane_in), .LANE_DATA_OUT(lane_out), .CDR_RELEASE(cdr_rel),
        .CDR_HALFRATE(cdr_hr), .CDR_OVERSAMPLE_SEL(cdr_os), .SERDES_PLL_DIVIDER_SEL(pll_div),
        .SERDES_PLL_ENABLE(pll_en), .EQUALIZER_MODE_SEL(eq_mode),
        .CHECKSUM_METHOD_SEL(cks_sel), .LINK_ENABLE(link_en),
        .LINK_SYNC_REQUEST_OUT_N(sync_n), .LMFC_PULSE(lmfc_p));
    sdlbc_tx_model u_tx (.clk_sys(clk_sys), .sys_rst(sys_rst), .sync_req_n(sync_n),
        .lane_data(lane_in));
    // ====================================================================
    // Clock, input capture for lane expectations, watchdog
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) prev_in <= lane_in;
    initial begin
        #300us;
        n_fail++;
        close_out();
    end
    // ====================================================================
    // Serial frame: 16-bit instruction then 8 data bits, MSB first
    task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] wd,
                       output logic [7:0] rv);
        logic [23:0] fr;
        fr = {rd, a, wd};
        rv = 8'h00;
        cs_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            sclk = 1'b0;
            sdi = fr[i];
            repeat (3) @(negedge clk_sys);
            if (i < 8) rv[i] = sdo;
            if (i < 8 && rd) `CHK(sdo_oe, 1'b1)
            sclk = 1'b1;
            repeat (2) @(negedge clk_sys);
        end
        sclk = 1'b0;
        repeat (3) @(negedge clk_sys);
        cs_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        `CHK(sdo_oe, 1'b0)
    endtask : spi
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] v;
        spi(1'b0, a, d, v);
    endtask : wr
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] v;
        spi(1'b1, a, 8'h00, v);
        `CHK(v, e)
    endtask : rd_chk
    // ====================================================================
    // Scenarios
    task automatic t_reset;
        logic [14:0] rw [6] = '{A_AUTOTUNE, A_PORT_CFG, A_SUBCLASS, A_LMFC_WIN, A_XBAR_LO, A_XBAR_HI};
        rd_chk(A_CDR_CLK, 8'h09);
        rd_chk(A_PLL_DIV, 8'h04);
        rd_chk(A_EQ_CFG, 8'h22);
        rd_chk(A_PLL_LOCK, 8'h00);
        rd_chk(A_SYNC_STA, 8'h00);
        rd_chk(15'h0000, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(rw[i], 8'hA5 ^ i[7:0]);
            rd_chk(rw[i], 8'hA5 ^ i[7:0]);
        end
        wr(A_AUTOTUNE, 8'h01);
        wr(A_PORT_CFG, 8'h01);
        wr(A_SUBCLASS, 8'h01);
    endtask : t_reset
    task automatic t_phy;
        wr(A_CDR_RST, 8'h00);
        `CHK(cdr_rel, 1'b0)
        wr(A_CDR_RST, 8'h01);
        `CHK(cdr_rel, 1'b1)
        for (int k = 0; k < 4; k++) begin
            wr(A_CDR_CLK, {2'h0, k[1], 3'h2, k[0], 1'h1});
            `CHK({cdr_hr, cdr_os}, k[1:0])
            wr(A_PLL_DIV, {6'h01, k[1:0]});
            `CHK(pll_div, k[1:0])
            wr(A_EQ_CFG, {k[1:0], 6'h22});
            `CHK(eq_mode, k[1:0])
            rd_chk(A_EQ_CFG, {k[1:0], 6'h22});
        end
        lock_in = 1'b1;
        rd_chk(A_PLL_LOCK, 8'h00);
        wr(A_PLL_EN, 8'h01);
        `CHK(pll_en, 1'b1)
        rd_chk(A_PLL_LOCK, 8'h01);
        wr(A_PLL_LOCK, 8'h00);
        lock_in = 1'b0;
        rd_chk(A_PLL_LOCK, 8'h00);
        lock_in = 1'b1;
        rd_chk(A_PLL_LOCK, 8'h01);
    endtask : t_phy
    task automatic t_sync;
        wr(A_LMFC_DEL, 8'h05);
        rd_chk(A_LMFC_DEL, 8'h05);
        wr(A_LMFC_WIN, 8'h03);
        rd_chk(A_LMFC_WIN, 8'h03);
        wr(A_SYNC_CTL, 8'h01);
        wr(A_SYNC_CTL, 8'h81);
        rd_chk(A_SYNC_CTL, 8'h81);
        sysref = 1'b1;
        repeat (2) @(negedge clk_sys);
        sysref = 1'b0;
        rd_chk(A_SYNC_STA, 8'h00);
        wr(A_SYNC_CTL, 8'hC1);
        rd_chk(A_SYNC_CTL, 8'hC1);
        sysref = 1'b1;
        repeat (2) @(negedge clk_sys);
        sysref = 1'b0;
        repeat (25) @(negedge clk_sys);
        `CHK(lmfc_p, 1'b0)
        @(negedge clk_sys);
        `CHK(lmfc_p, 1'b1)
        rd_chk(A_SYNC_STA, 8'h08);
        rd_chk(A_SYNC_CTL, 8'h81);
        wr(A_SYNC_STA, 8'h00);
        rd_chk(A_SYNC_STA, 8'h08);
    endtask : t_sync
    task automatic lane_cmp(input int n);
        logic [39:0] e;
        repeat (6) begin
            @(negedge clk_sys);
            for (int i = 0; i < 4; i++) begin
                e[i*10+:10] = (i > n) ? 10'h000 : prev_in[(3-i)*10+:10] ^ {10{~i[0]}};
            end
            `CHK(lane_out, e)
        end
    endtask : lane_cmp
    task automatic t_lanes;
        wr(A_XBAR_LO, 8'h13);
        wr(A_XBAR_HI, 8'h01);
        wr(A_POLARITY, 8'h05);
        `CHK(lane_out, 40'h0)
        `CHK(sync_n, 1'b0)
        wr(A_LINK_CTL, 8'h41);
        `CHK({link_en, cks_sel}, 2'h3)
        `CHK(sync_n, 1'b1)
        lane_cmp(3);
        lane_m1 = 5'h01;
        lane_cmp(1);
        wr(A_LINK_CTL, 8'h00);
        `CHK({link_en, cks_sel, lane_out}, 42'h0)
    endtask : t_lanes
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    initial begin
        {cs_n, sclk, sdi, lock_in, sysref, sys_rst} = 6'h21;
        sys_rst = 1'b1;
        lane_m1 = 5'h03;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        @(negedge clk_sys);
        t_reset();
        t_phy();
        t_sync();
        t_lanes();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
